// File: pkg/acp_pkg.sv
// Constants and types for the ATM cell processor
// Function
// (RULE1) Cell processor enabled in cell-bus mode, or packet mode with select high.
// (RULE2) Serial bytes go MSB first; first bit sits in bit 7.
// (RULE3) Processing off: no padding, HEC or errors; reorder and scramble remain.
// (RULE4) Processing off: FIFO read continuously, FFh while empty until above threshold.
// (RULE5) Each 32-bit FIFO word is split into bytes before reordering.
// (RULE6) Bit reordering reverses each byte end for end; the code leaves transmit fill-cell bytes unreordered.
// (RULE7) Fill cells with programmable header and payload when no complete cell.
// (RULE8) HEC is CRC-8, x^8+x^2+x+1, over four header bytes, after header.
// (RULE9) Coset x^6+x^4+x^2+1 is XORed into the HEC unless disabled.
// (RULE10) FIFO HEC is passed or overwritten; otherwise computed HEC is inserted.
// (RULE11) HEC mask inverted on error trigger from input or counted register.
// (RULE12) Self-synchronous x^43+1 scrambler over payload only or whole stream.
// (RULE13) DSS x^31+x^28+1; HEC bit1 with bit 211 back, bit2 current.
// (RULE14) DSS only in bit mode; processing off scrambles whole stream.
// (RULE15) Output serial in bit mode, whole bytes in octet mode.
// (RULE16) Receive processing off bypasses cell functions but still descrambles, reorders.
// (RULE17) Receive descrambles payload, whole stream or DSS as selected.
// (RULE18) Bit mode descrambles per bit then packs; octet mode per byte, no DSS.
// (RULE19) Acquisition loads HEC samples, counts cells, goes to verification at 16.
// (RULE20) Verification counts matches up, mismatches down; steady at 24, back at 8.
// (RULE21) Steady state counts up to 24, down on mismatch, acquisition at 16.
// (RULE22) Cells dropped during acquisition and verification.
// (RULE23) Reset clears counter, scrambler states, puts synchroniser in acquisition; the code loads both DSS LFSRs with DSS_SEED instead.
package acp_pkg;
   localparam logic [5:0] IDX_HEC = 6'h04;
   localparam logic [5:0] IDX_PAY = 6'h05;
   localparam logic [5:0] IDX_LAST = 6'h34;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] COSET = 8'h55;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam logic [1:0] SCR_OFF = 2'h0;
   localparam logic [1:0] SCR_PAY = 2'h1;
   localparam logic [1:0] SCR_ALL = 2'h2;
   localparam logic [1:0] SCR_DSS = 2'h3;
   localparam logic [1:0] DM_GEN = 2'h0;
   localparam logic [1:0] DM_OLD = 2'h1;
   localparam logic [1:0] DM_NONE = 2'h2;
   localparam logic [4:0] CONF_VER = 5'h10;
   localparam logic [4:0] CONF_STD = 5'h18;
   localparam logic [4:0] CONF_LOST = 5'h08;
   localparam logic [4:0] CONF_MAX = 5'h18;
   localparam logic [4:0] CONF_DROP = 5'h10;
   localparam logic [30:0] DSS_SEED = 31'h00000001;
   localparam int FIFO_W = 32;
   localparam int FIFO_D = 8;
   typedef enum logic [2:0] {
      SS_ACQ = 3'b001,
      SS_VER = 3'b010,
      SS_STD = 3'b100
   } acp_sync_t;
endpackage

// File: rtl/acp_top.sv
// ATM cell processor: transmit and receive byte paths with word FIFO
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Word FIFO
module acp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic room;
      logic empty;
   } acp_fifo_t;

   acp_fifo_t st_reg;
   acp_fifo_t st_next;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] adv(input logic [AW-1:0] p);
      adv = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   always_comb begin
      st_next = st_reg;
      push = in_valid & st_reg.room;
      pop = out_ready & ~st_reg.empty;
      if (push) begin
         st_next.mem[st_reg.wp] = in_data;
         st_next.wp = adv(st_reg.wp);
      end
      if (pop) begin
         st_next.rp = adv(st_reg.rp);
      end
      st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      st_next.room = st_next.cnt != (AW+1)'(DEPTH);
      st_next.empty = st_next.cnt == '0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.empty <= 1'b1;
         st_reg.room <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign in_ready = st_reg.room;
   assign out_valid = ~st_reg.empty;
   assign out_data = st_reg.mem[st_reg.rp];
endmodule

////////////////////////////////////////////////////////////////////////////
// Cell processor top
module acp_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cell_bus_mode,
   input wire logic cell_in_packet_mode_select,
   input wire logic tx_proc_en,
   input wire logic rx_proc_en,
   input wire logic bit_reorder_en,
   input wire logic octet_mode,
   input wire logic [1:0] tx_scr_mode,
   input wire logic [1:0] rx_scr_mode,
   input wire logic coset_en,
   input wire logic tx_has_hec,
   input wire logic hec_pass_en,
   input wire logic [31:0] fill_header,
   input wire logic [7:0] fill_payload,
   input wire logic [7:0] err_mask,
   input wire logic err_use_input,
   input wire logic [7:0] err_count,
   input wire logic [7:0] err_period,
   input wire logic err_start,
   input wire logic manual_error_insert_in,
   input wire logic tx_cell_avail,
   input wire logic tx_above_ae,
   input wire logic [31:0] tx_word,
   input wire logic tx_word_valid,
   output logic tx_word_ready,
   input wire logic line_tx_ready,
   output logic [7:0] tx_byte_out,
   output logic tx_bit_out,
   output logic tx_out_valid,
   input wire logic rx_valid,
   input wire logic rx_cell_start,
   input wire logic rx_bit,
   input wire logic [7:0] rx_byte,
   output logic [31:0] rx_word,
   output logic rx_word_valid,
   output logic cell_proc_sel,
   output logic [2:0] sync_state,
   output logic [4:0] sync_conf
);
   typedef struct packed {
      logic sel;
      logic [2:0] ms;
      logic ml;
      logic [5:0] tidx;
      logic tfill;
      logic [31:0] tw;
      logic twok;
      logic [1:0] tsel;
      logic [7:0] tcrc;
      logic [7:0] tsh;
      logic [2:0] tbc;
      logic [7:0] tout;
      logic tbit;
      logic tvld;
      logic tstv;
      logic [42:0] t43;
      logic [30:0] tdl;
      logic [210:0] tdh;
      logic earm;
      logic eon;
      logic econt;
      logic [7:0] eleft;
      logic [7:0] eper;
      logic [5:0] ridx;
      logic [7:0] racc;
      logic [2:0] rbc;
      logic [7:0] rcrc;
      logic rkeep;
      logic [42:0] r43;
      logic [30:0] rdl;
      logic [210:0] rdh;
      acp_pkg::acp_sync_t sst;
      logic [4:0] conf;
      logic [31:0] rw;
      logic [1:0] rsel;
      logic [31:0] rout;
      logic rwv;
   } acp_state_t;

   acp_state_t st_reg;
   acp_state_t st_next;
   logic f_valid;
   logic [31:0] f_data;
   logic pop;
   logic take;
   logic avail;
   logic fire;
   logic fill;
   logic hec_slot;
   logic sok;
   logic [7:0] b;
   logic [7:0] sb;
   logic [7:0] hec;
   logic [50:0] sr;
   logic [249:0] dr;
   logic [242:0] db;
   logic [43:0] sbit;
   logic rb;
   logic rdone;
   logic rdss;
   logic rss;
   logic keepv;
   logic mism;
   logic [5:0] rix;
   logic [2:0] rbcv;
   logic [7:0] rbyte;
   logic [7:0] ob;
   logic [7:0] exp_hec;
   logic [1:0] dm;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] rev8(input logic [7:0] d);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7-i];
      end
      return r;
   endfunction

   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] x;
      logic fb;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         fb = x[7] ^ d[i];
         x = {x[6:0], 1'b0} ^ (fb ? acp_pkg::CRC_POLY : 8'h00);
      end
      return x;
   endfunction

   // Self-synchronous x^43+1, one bit: {state, out}
   function automatic logic [43:0] ss_bit(input logic [42:0] s,
                                          input logic d,
                                          input logic desc);
      logic o;
      o = d ^ s[42];
      return {s[41:0], desc ? d : o, o};
   endfunction

   function automatic logic [50:0] ss_byte(input logic [42:0] s,
                                           input logic [7:0] d,
                                           input logic desc);
      logic [43:0] t;
      logic [7:0] o;
      t = {s, 1'b0};
      o = '0;
      for (int i = 7; i >= 0; i--) begin
         t = ss_bit(t[43:1], d[i], desc);
         o[i] = t[0];
      end
      return {t[43:1], o};
   endfunction

   // Distributed sample generator, one bit: {lfsr, history, out}
   function automatic logic [242:0] dss_bit(input logic [30:0] l,
                                            input logic [210:0] h,
                                            input logic d,
                                            input logic [1:0] m);
      logic g;
      logic o;
      g = l[30] ^ l[27];
      if (m == acp_pkg::DM_OLD) begin
         o = d ^ h[210];
      end else if (m == acp_pkg::DM_NONE) begin
         o = d;
      end else begin
         o = d ^ g;
      end
      return {l[29:0], g, h[209:0], g, o};
   endfunction

   function automatic logic [1:0] dss_mode(input logic hs,
                                           input logic [2:0] pos);
      if (!hs) begin
         return acp_pkg::DM_GEN;
      end
      if (pos == 3'h0) begin
         return acp_pkg::DM_OLD;
      end
      return (pos == 3'h1) ? acp_pkg::DM_GEN : acp_pkg::DM_NONE;
   endfunction

   function automatic logic [249:0] dss_byte(input logic [30:0] l,
                                             input logic [210:0] h,
                                             input logic [7:0] d,
                                             input logic hs);
      logic [242:0] t;
      logic [7:0] o;
      t = {l, h, 1'b0};
      o = '0;
      for (int i = 0; i < 8; i++) begin
         t = dss_bit(t[242:212], t[211:1], d[7-i], dss_mode(hs, 3'(i)));
         o[7-i] = t[0];
      end
      return {t[242:1], o};
   endfunction

   acp_fifo #(
      .WIDTH(acp_pkg::FIFO_W),
      .DEPTH(acp_pkg::FIFO_D)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(tx_word_valid),
      .in_ready(tx_word_ready),
      .in_data(tx_word),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next = st_reg;
      pop = 1'b0;
      take = 1'b0;
      avail = 1'b0;
      fire = 1'b0;
      fill = st_reg.tfill;
      hec_slot = 1'b0;
      b = acp_pkg::FILL_BYTE;
      hec = 8'h00;
      sr = '0;
      dr = '0;
      db = '0;
      sbit = '0;
      rb = rx_bit;
      rdone = 1'b0;
      rbyte = rx_byte;
      ob = 8'h00;
      exp_hec = 8'h00;
      mism = 1'b0;
      dm = acp_pkg::DM_GEN;
      st_next.sel = cell_bus_mode | cell_in_packet_mode_select; // RULE1
      st_next.tvld = 1'b0;
      st_next.rwv = 1'b0;
      if (tx_above_ae) begin
         st_next.tstv = 1'b0; // RULE4
      end
      sok = st_reg.twok | f_valid;
      sb = st_reg.twok ? st_reg.tw[{~st_reg.tsel, 3'b000} +: 8]
                       : f_data[31:24]; // RULE5
      // Transmit
      if (st_reg.sel & line_tx_ready) begin
         if (~octet_mode & (st_reg.tbc != 3'h0)) begin
            st_next.tbit = st_reg.tsh[7]; // RULE2
            st_next.tsh = {st_reg.tsh[6:0], 1'b0};
            st_next.tbc = st_reg.tbc - 3'h1;
            st_next.tvld = 1'b1;
         end else if (~tx_proc_en) begin
            avail = 1'b1; // RULE3
            if (sok & (st_reg.twok | ~st_reg.tstv)) begin
               take = 1'b1;
               b = bit_reorder_en ? rev8(sb) : sb;
            end else if (~sok) begin
               st_next.tstv = 1'b1; // RULE4
            end
         end else begin
            hec_slot = st_reg.tidx == acp_pkg::IDX_HEC;
            if (st_reg.tidx == 6'h00) begin
               fill = ~tx_cell_avail; // RULE7
            end
            st_next.tfill = fill;
            if (fill) begin
               avail = 1'b1;
               b = (st_reg.tidx < acp_pkg::IDX_HEC)
                   ? fill_header[{~st_reg.tidx[1:0], 3'b000} +: 8]
                   : fill_payload; // RULE7
            end else if (hec_slot) begin
               avail = ~tx_has_hec | f_valid;
               pop = tx_has_hec & f_valid;
               b = f_data[31:24];
            end else begin
               avail = sok;
               take = sok;
               b = sb;
            end
            if (bit_reorder_en & ~fill) begin
               b = rev8(b); // RULE6
            end
            if (hec_slot) begin
               hec = st_reg.tcrc ^ (coset_en ? acp_pkg::COSET : 8'h00); // RULE8 RULE9
               if (~fill & tx_has_hec & hec_pass_en & avail) begin
                  hec = b; // RULE10
               end
               if (avail) begin
                  if (err_use_input) begin
                     fire = st_reg.earm;
                     st_next.earm = 1'b0;
                  end else if (st_reg.eon & (st_reg.eper == 8'h00)) begin
                     fire = 1'b1;
                     st_next.eper = err_period;
                     if (~st_reg.econt) begin
                        st_next.eleft = st_reg.eleft - 8'h01;
                        st_next.eon = st_reg.eleft != 8'h01;
                     end
                  end else if (st_reg.eon) begin
                     st_next.eper = st_reg.eper - 8'h01;
                  end
               end
               b = fire ? (hec ^ err_mask) : hec; // RULE11
            end else if (avail & (st_reg.tidx < acp_pkg::IDX_HEC)) begin
               st_next.tcrc = crc8((st_reg.tidx == 6'h00) ? 8'h00
                                   : st_reg.tcrc, b); // RULE8
            end
         end
         if (avail) begin
            if (tx_proc_en & (tx_scr_mode == acp_pkg::SCR_DSS)) begin
               if (~octet_mode) begin
                  dr = dss_byte(st_reg.tdl, st_reg.tdh, b, hec_slot); // RULE13 RULE14
                  st_next.tdl = dr[249:219];
                  st_next.tdh = dr[218:8];
                  b = dr[7:0];
               end
            end else if ((tx_scr_mode == acp_pkg::SCR_ALL) |
                         ((tx_scr_mode != acp_pkg::SCR_OFF) & ~tx_proc_en) |
                         ((tx_scr_mode == acp_pkg::SCR_PAY) &
                          (st_reg.tidx >= acp_pkg::IDX_PAY))) begin
               sr = ss_byte(st_reg.t43, b, 1'b0); // RULE12 RULE14
               st_next.t43 = sr[50:8];
               b = sr[7:0];
            end
            if (tx_proc_en) begin
               st_next.tidx = (st_reg.tidx == acp_pkg::IDX_LAST) ? 6'h00
                              : st_reg.tidx + 6'h01;
            end
            st_next.tout = b; // RULE15
            st_next.tvld = 1'b1;
            st_next.tbit = b[7]; // RULE2
            st_next.tsh = {b[6:0], 1'b0};
            st_next.tbc = octet_mode ? 3'h0 : 3'h7; // RULE15
         end
      end
      if (take) begin
         if (st_reg.twok) begin
            st_next.tsel = st_reg.tsel + 2'h1;
            st_next.twok = st_reg.tsel != 2'h3;
         end else begin
            pop = 1'b1;
            st_next.tw = f_data;
            st_next.twok = 1'b1;
            st_next.tsel = 2'h1;
         end
      end
      // Error trigger sources; arming wins over the clear above
      st_next.ms = {st_reg.ms[1:0], manual_error_insert_in};
      if (st_reg.ms[2] == st_reg.ms[1]) begin
         st_next.ml = st_reg.ms[2];
      end
      if (st_next.ml & ~st_reg.ml & err_use_input) begin
         st_next.earm = 1'b1; // RULE11
      end
      if (err_start & ~err_use_input) begin
         st_next.eon = 1'b1; // RULE11
         st_next.econt = err_count == 8'h00;
         st_next.eleft = err_count;
         st_next.eper = 8'h00;
      end
      // Receive
      rix = rx_cell_start ? 6'h00 : st_reg.ridx;
      rbcv = rx_cell_start ? 3'h0 : st_reg.rbc;
      rdss = rx_proc_en & (rx_scr_mode == acp_pkg::SCR_DSS) & ~octet_mode;
      rss = (rx_scr_mode == acp_pkg::SCR_ALL) |
            ((rx_scr_mode != acp_pkg::SCR_OFF) & ~rx_proc_en) |
            ((rx_scr_mode == acp_pkg::SCR_PAY) & rx_proc_en &
             (rix >= acp_pkg::IDX_PAY)); // RULE16 RULE17
      keepv = ~rdss | (rx_cell_start ? (st_reg.sst == acp_pkg::SS_STD)
                                     : st_reg.rkeep); // RULE22
      if (st_reg.sel & rx_valid) begin
         st_next.rkeep = keepv;
         if (~octet_mode) begin
            if (rdss) begin
               dm = dss_mode(rix == acp_pkg::IDX_HEC, rbcv);
               db = dss_bit(st_reg.rdl, st_reg.rdh, rx_bit, dm); // RULE17
               st_next.rdl = db[242:212];
               st_next.rdh = db[211:1];
               rb = db[0];
            end else if (rss) begin
               sbit = ss_bit(st_reg.r43, rx_bit, 1'b1); // RULE18
               st_next.r43 = sbit[43:1];
               rb = sbit[0];
            end
            rbyte = {st_reg.racc[6:0], rb}; // RULE2
            st_next.racc = rbyte;
            st_next.rbc = rbcv + 3'h1;
            rdone = rbcv == 3'h7;
         end else begin
            if (rss) begin
               sr = ss_byte(st_reg.r43, rx_byte, 1'b1); // RULE18
               st_next.r43 = sr[50:8];
               rbyte = sr[7:0];
            end
            rdone = 1'b1;
         end
         if (rdone) begin
            st_next.ridx = rix;
            if (rx_proc_en) begin
               st_next.ridx = (rix == acp_pkg::IDX_LAST) ? 6'h00
                              : rix + 6'h01;
            end
            if (rx_proc_en & (rix < acp_pkg::IDX_HEC)) begin
               st_next.rcrc = crc8((rix == 6'h00) ? 8'h00
                                   : st_reg.rcrc, rbyte);
            end
            if (rdss & (rix == acp_pkg::IDX_HEC)) begin
               exp_hec = st_reg.rcrc ^ (coset_en ? acp_pkg::COSET : 8'h00);
               mism = rbyte[7:6] != exp_hec[7:6];
               unique case (st_reg.sst)
                  acp_pkg::SS_ACQ: begin
                     st_next.rdl[0] = st_next.rdl[0] ^ rbyte[6] ^ exp_hec[6]; // RULE19
                     st_next.rdh[0] = st_next.rdh[0] ^ rbyte[7] ^ exp_hec[7];
                     st_next.conf = st_reg.conf + 5'h01;
                     if (st_next.conf >= acp_pkg::CONF_VER) begin
                        st_next.sst = acp_pkg::SS_VER; // RULE19
                     end
                  end
                  acp_pkg::SS_VER: begin
                     st_next.conf = mism ? st_reg.conf - 5'h01
                                         : st_reg.conf + 5'h01; // RULE20
                     if (st_next.conf == acp_pkg::CONF_STD) begin
                        st_next.sst = acp_pkg::SS_STD; // RULE20
                     end else if (st_next.conf == acp_pkg::CONF_LOST) begin
                        st_next.sst = acp_pkg::SS_ACQ; // RULE20
                     end
                  end
                  acp_pkg::SS_STD: begin
                     if (mism) begin
                        st_next.conf = st_reg.conf - 5'h01; // RULE21
                     end else if (st_reg.conf < acp_pkg::CONF_MAX) begin
                        st_next.conf = st_reg.conf + 5'h01; // RULE21
                     end
                     if (st_next.conf == acp_pkg::CONF_DROP) begin
                        st_next.sst = acp_pkg::SS_ACQ; // RULE21
                     end
                  end
                  default: begin
                     st_next.sst = acp_pkg::SS_ACQ;
                  end
               endcase
            end
            if (keepv) begin
               ob = bit_reorder_en ? rev8(rbyte) : rbyte; // RULE6 RULE16
               st_next.rw[{~st_reg.rsel, 3'b000} +: 8] = ob;
               st_next.rsel = st_reg.rsel + 2'h1;
               if (st_reg.rsel == 2'h3) begin
                  st_next.rout = {st_reg.rw[31:8], ob};
                  st_next.rwv = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0; // RULE23
         st_reg.sst <= acp_pkg::SS_ACQ; // RULE23
         st_reg.tdl <= acp_pkg::DSS_SEED;
         st_reg.rdl <= acp_pkg::DSS_SEED;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tx_byte_out = st_reg.tout;
   assign tx_bit_out = st_reg.tbit;
   assign tx_out_valid = st_reg.tvld;
   assign rx_word = st_reg.rout;
   assign rx_word_valid = st_reg.rwv;
   assign cell_proc_sel = st_reg.sel;
   assign sync_state = st_reg.sst;
   assign sync_conf = st_reg.conf;
endmodule

// File: testbench/acp_monitor.sv
// Port checker for the cell processor
`timescale 1ns/100ps
module acp_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cell_bus_mode,
   input wire logic cell_in_packet_mode_select,
   input wire logic line_tx_ready,
   input wire logic tx_out_valid,
   input wire logic cell_proc_sel,
   input wire logic rx_word_valid,
   input wire logic [2:0] sync_state,
   input wire logic [4:0] sync_conf
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_sel_mode: assert property ($past(rst_n) |->
      cell_proc_sel == $past(cell_bus_mode | cell_in_packet_mode_select))
      else $error("cell processor select wrong");
   a_tx_served: assert property (tx_out_valid |->
      $past(line_tx_ready & cell_proc_sel)) else $error("unrequested output");
   a_sync_onehot: assert property ($onehot(sync_state))
      else $error("sync state not one-hot");
   a_conf_ceiling: assert property (sync_conf <= 5'h18)
      else $error("confidence above ceiling");
   a_conf_step: assert property ($past(rst_n) |->
      sync_conf - $past(sync_conf) inside {5'h00, 5'h01, 5'h1F})
      else $error("confidence jumped");
   a_steady_floor: assert property (sync_state == acp_pkg::SS_STD |->
      sync_conf >= 5'h10) else $error("steady below floor");
   a_verify_floor: assert property (sync_state == acp_pkg::SS_VER |->
      sync_conf >= 5'h08) else $error("verify below floor");
   a_rx_word_gap: assert property (rx_word_valid |=>
      !rx_word_valid [*3]) else $error("receive words too close");
   cover property (tx_out_valid);
   cover property (rx_word_valid);
   cover property ($rose(cell_proc_sel));
endmodule
bind acp_top acp_chk u_chk (.clk, .rst_n, .cell_bus_mode,
   .cell_in_packet_mode_select, .line_tx_ready, .tx_out_valid,
   .cell_proc_sel, .rx_word_valid, .sync_state, .sync_conf);

// File: testbench/acp_line.sv
// Line side model collecting transmit bytes
`timescale 1ns/100ps
module acp_line (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic slow,
   input wire logic octet_mode,
   input wire logic [7:0] tx_byte_out,
   input wire logic tx_bit_out,
   input wire logic tx_out_valid,
   output logic line_tx_ready
);
   logic [7:0] q[$];
   logic [7:0] sh = 8'h00;
   logic [2:0] n = 3'h0;
   logic ph = 1'h0;
   assign line_tx_ready = en & (ph | ~slow);
   always @(posedge clk or negedge rst_n) begin
      ph <= ~ph;
      if (!rst_n) begin
         n <= 3'h0;
      end else if (tx_out_valid && octet_mode) begin
         q.push_back(tx_byte_out);
      end else if (tx_out_valid) begin
         sh = {sh[6:0], tx_bit_out};
         n <= n + 3'h1;
         if (n == 3'h7) q.push_back(sh);
      end
   end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the cell processor
`timescale 1ns/100ps
module tb;
   logic clk, rst_n, cell_bus_mode, cell_in_packet_mode_select, tx_proc_en;
   logic rx_proc_en, bit_reorder_en, octet_mode, coset_en, tx_has_hec;
   logic hec_pass_en, err_use_input, err_start, manual_error_insert_in;
   logic tx_cell_avail, tx_above_ae, tx_word_valid, tx_word_ready, en, slow;
   logic line_tx_ready, tx_bit_out, tx_out_valid, rx_valid, rx_cell_start;
   logic rx_bit, rx_word_valid, cell_proc_sel;
   logic [1:0] tx_scr_mode, rx_scr_mode;
   logic [7:0] fill_payload, err_mask, ecnt, err_period, rx_byte, tx_byte_out;
   logic [31:0] fill_header, tx_word, rx_word;
   logic [2:0] sync_state;
   logic [4:0] sync_conf;
   int err_count = 0, checks = 0;
   acp_top DUT (.err_count(ecnt), .*);
   acp_line u_line (.*);
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (e !== g) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic do_reset();
      rst_n <= 1'h0;
      repeat (10) @(posedge clk);
      u_line.q.delete();
      rst_n <= 1'h1;
      @(posedge clk);
   endtask
   task automatic need(int k);
      int t;
      t = 0;
      while (u_line.q.size() < k && t < 3000) begin
         @(posedge clk);
         t++;
      end
      if (u_line.q.size() < k) begin
         err_count++;
         end_of_test();
      end
   endtask
   function automatic logic [7:0] crc(logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--)
         c = {c[6:0], 1'h0} ^ (c[7] ^ h[i] ? 8'h07 : 8'h00);
      return c;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      int j;
      {clk, rst_n, cell_bus_mode, cell_in_packet_mode_select, tx_proc_en,
       rx_proc_en, bit_reorder_en, octet_mode, coset_en, tx_has_hec,
       hec_pass_en, err_use_input, err_start, manual_error_insert_in,
       tx_cell_avail, tx_above_ae, tx_word_valid, en, slow, rx_valid,
       rx_cell_start, rx_bit, tx_scr_mode, rx_scr_mode, err_mask, ecnt,
       err_period, rx_byte, tx_word} = '0;
      fill_header = 32'hA5C3_0F11;
      fill_payload = 8'h6B;
      do_reset();
      chk("sync_state", 32'h1, sync_state);
      chk("sync_conf", 32'h0, sync_conf);
      chk("tx_word_ready", 32'h1, tx_word_ready);
      for (int m = 0; m < 4; m++) begin
         cell_bus_mode <= m[1];
         cell_in_packet_mode_select <= m[0];
         repeat (2) @(posedge clk);
         chk("cell_proc_sel", 32'(m != 0), cell_proc_sel);
      end
      $display("test mode select done");
      for (int k = 0; k < 2; k++) begin
         octet_mode <= k[0];
         coset_en <= ~k[0];
         slow <= k[0];
         tx_proc_en <= 1'h1;
         err_mask <= k[0] ? 8'h81 : 8'h00;
         ecnt <= 8'h01;
         do_reset();
         err_start <= 1'h1;
         @(posedge clk);
         err_start <= 1'h0;
         en <= 1'h1;
         need(6);
         en <= 1'h0;
         for (int i = 0; i < 4; i++)
            chk("header", fill_header[31-8*i -: 8], u_line.q[i]);
         chk("hec", crc(fill_header) ^ (k[0] ? 8'h81 : acp_pkg::COSET),
             u_line.q[4]);
         chk("payload", fill_payload, u_line.q[5]);
         $display("test fill cell %0d done", k);
      end
      tx_proc_en <= 1'h0;
      octet_mode <= 1'h1;
      bit_reorder_en <= 1'h1;
      slow <= 1'h0;
      do_reset();
      en <= 1'h1;
      need(2);
      chk("idle", 32'hFF, u_line.q[0]);
      tx_word <= 32'h1234_5678;
      tx_word_valid <= 1'h1;
      tx_above_ae <= 1'h1;
      @(posedge clk);
      tx_word_valid <= 1'h0;
      need(40);
      j = 0;
      while (j < 36 && u_line.q[j] == 8'hFF) j++;
      for (int i = 0; i < 4; i++)
         chk("clear", (32'h482C_6A1E >> (24 - 8 * i)) & 32'hFF,
             u_line.q[j+i]);
      for (int i = 0; i < 4; i++) begin
         rx_byte <= 8'h12 + 8'h22 * i;
         rx_cell_start <= (i == 0);
         rx_valid <= 1'h1;
         @(posedge clk);
      end
      rx_valid <= 1'h0;
      j = 0;
      while (rx_word_valid !== 1'h1 && j < 5) begin
         @(posedge clk);
         j++;
      end
      chk("rx_word_valid", 32'h1, rx_word_valid);
      chk("rx_word", 32'h482C_6A1E, rx_word);
      $display("test clear channel done");
      end_of_test();
   end
endmodule
